// ### triple_dff.sv
`include "triple_dff_cfg.svh"
`default_nettype none
module triple_dff
    import triple_dff_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic shared_clock_i,
    input wire logic shared_set_i,
    input wire logic shared_clear_i,
    input wire stage_vec_t stage_clock_i,
    input wire stage_vec_t stage_set_i,
    input wire stage_vec_t stage_clear_i,
    input wire stage_vec_t stage_data_in_i,
    output stage_vec_t stage_out_o,
    output stage_vec_t stage_out_inverted_o
);

////////////////////////////////////////////////////////////////////////
// The pins are sampled on clock_i, so "asynchronous" set and clear act
// on the next system clock edge with clk_en_i high; this keeps the design single-clocked.

stage_vec_t master_ff, nxt_master;
stage_vec_t prev_clk_ff, nxt_prev_clk;
stage_vec_t stage_out_ff, nxt_stage_out;
stage_vec_t stage_out_inv_ff, nxt_stage_out_inv;
stage_vec_t eff_clk;

always_comb begin
    for (int i = 0; i < `STAGE_COUNT; i++) begin
        eff_clk[i] = stage_clock_i[i] | shared_clock_i;
        nxt_master[i] = master_ff[i];
        nxt_stage_out[i] = stage_out_ff[i];
        // Master tracks data while both clocks are low.
        if (!eff_clk[i]) begin
            nxt_master[i] = stage_data_in_i[i];
        end
        // Rising edge moves the held master value out.
        if (eff_clk[i] && !prev_clk_ff[i]) begin
            nxt_stage_out[i] = master_ff[i];
        end
        // Direct inputs override the clocks; clear wins if both are
        // driven, a case the driving logic must avoid.
        if (stage_set_i[i] || shared_set_i) begin
            nxt_stage_out[i] = 1'h1;
        end
        if (stage_clear_i[i] || shared_clear_i) begin
            nxt_stage_out[i] = 1'h0;
        end
        nxt_prev_clk[i] = eff_clk[i];
        nxt_stage_out_inv[i] = ~nxt_stage_out[i];
    end
end

// Three stages in one vector of flip-flops.
always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
        master_ff <= {`STAGE_COUNT{`STAGE_RESET_VAL}};
        prev_clk_ff <= 3'h7;
        stage_out_ff <= {`STAGE_COUNT{`STAGE_RESET_VAL}};
        stage_out_inv_ff <= 3'h7;
    end else if (clk_en_i) begin
        master_ff <= nxt_master;
        prev_clk_ff <= nxt_prev_clk;
        stage_out_ff <= nxt_stage_out;
        stage_out_inv_ff <= nxt_stage_out_inv;
    end
end

assign stage_out_o = stage_out_ff;
assign stage_out_inverted_o = stage_out_inv_ff;

////////////////////////////////////////////////////////////////////////

default clocking cb @(posedge clock_i); endclocking
default disable iff (!rst_n_i);

// The reset check carries its own disable so it can watch reset itself.
property p_rst;
    @(posedge clock_i) disable iff (1'h0)
    !rst_n_i |=> stage_out_o == 3'h0 && stage_out_inverted_o == 3'h7;
endproperty
a_rst: assert property (p_rst)
    else $error("reset values wrong");

property p_compl;
    stage_out_o == ~stage_out_inverted_o;
endproperty
a_compl: assert property (p_compl)
    else $error("outputs not complementary");

////////////////////////////////////////////////////////////////////////
// Direct set and clear, one check per stage and kind.

property p_set0;
    clk_en_i && (stage_set_i[0] || shared_set_i) && !stage_clear_i[0]
        && !shared_clear_i |=> stage_out_o[0];
endproperty
a_set0: assert property (p_set0)
    else $error("set did not force high");

property p_set1;
    clk_en_i && (stage_set_i[1] || shared_set_i) && !stage_clear_i[1]
        && !shared_clear_i |=> stage_out_o[1];
endproperty
a_set1: assert property (p_set1)
    else $error("set did not force high");

property p_set2;
    clk_en_i && (stage_set_i[2] || shared_set_i) && !stage_clear_i[2]
        && !shared_clear_i |=> stage_out_o[2];
endproperty
a_set2: assert property (p_set2)
    else $error("set did not force high");

property p_clr0;
    clk_en_i && (stage_clear_i[0] || shared_clear_i) |=> !stage_out_o[0];
endproperty
a_clr0: assert property (p_clr0)
    else $error("clear did not force low");

property p_clr1;
    clk_en_i && (stage_clear_i[1] || shared_clear_i) |=> !stage_out_o[1];
endproperty
a_clr1: assert property (p_clr1)
    else $error("clear did not force low");

property p_clr2;
    clk_en_i && (stage_clear_i[2] || shared_clear_i) |=> !stage_out_o[2];
endproperty
a_clr2: assert property (p_clr2)
    else $error("clear did not force low");

////////////////////////////////////////////////////////////////////////
// Clocked capture: the value seen while the clock was low comes out.

property p_edge0;
    clk_en_i && !(stage_clock_i[0] | shared_clock_i) ##1
        clk_en_i && (stage_clock_i[0] | shared_clock_i) && !stage_set_i[0]
        && !stage_clear_i[0] && !shared_set_i && !shared_clear_i
        |=> stage_out_o[0] == $past(stage_data_in_i[0], 2);
endproperty
a_edge0: assert property (p_edge0)
    else $error("edge capture wrong");

property p_edge1;
    clk_en_i && !(stage_clock_i[1] | shared_clock_i) ##1
        clk_en_i && (stage_clock_i[1] | shared_clock_i) && !stage_set_i[1]
        && !stage_clear_i[1] && !shared_set_i && !shared_clear_i
        |=> stage_out_o[1] == $past(stage_data_in_i[1], 2);
endproperty
a_edge1: assert property (p_edge1)
    else $error("edge capture wrong");

property p_edge2;
    clk_en_i && !(stage_clock_i[2] | shared_clock_i) ##1
        clk_en_i && (stage_clock_i[2] | shared_clock_i) && !stage_set_i[2]
        && !stage_clear_i[2] && !shared_set_i && !shared_clear_i
        |=> stage_out_o[2] == $past(stage_data_in_i[2], 2);
endproperty
a_edge2: assert property (p_edge2)
    else $error("edge capture wrong");

// A clock that stays high must not move the output a second time.
property p_hold0;
    clk_en_i && eff_clk[0] && prev_clk_ff[0] && !stage_set_i[0]
        && !stage_clear_i[0] && !shared_set_i && !shared_clear_i
        |=> $stable(stage_out_o[0]);
endproperty
a_hold0: assert property (p_hold0)
    else $error("output moved without edge");

property p_hold1;
    clk_en_i && eff_clk[1] && prev_clk_ff[1] && !stage_set_i[1]
        && !stage_clear_i[1] && !shared_set_i && !shared_clear_i
        |=> $stable(stage_out_o[1]);
endproperty
a_hold1: assert property (p_hold1)
    else $error("output moved without edge");

property p_hold2;
    clk_en_i && eff_clk[2] && prev_clk_ff[2] && !stage_set_i[2]
        && !stage_clear_i[2] && !shared_set_i && !shared_clear_i
        |=> $stable(stage_out_o[2]);
endproperty
a_hold2: assert property (p_hold2)
    else $error("output moved without edge");

////////////////////////////////////////////////////////////////////////
// Master section: follows data while low, holds while either clock is high.

property p_master0;
    clk_en_i && !eff_clk[0] |=> master_ff[0] == $past(stage_data_in_i[0]);
endproperty
a_master0: assert property (p_master0)
    else $error("master not following");

property p_master1;
    clk_en_i && !eff_clk[1] |=> master_ff[1] == $past(stage_data_in_i[1]);
endproperty
a_master1: assert property (p_master1)
    else $error("master not following");

property p_master2;
    clk_en_i && !eff_clk[2] |=> master_ff[2] == $past(stage_data_in_i[2]);
endproperty
a_master2: assert property (p_master2)
    else $error("master not following");

property p_mhold0;
    clk_en_i && eff_clk[0] |=> $stable(master_ff[0]);
endproperty
a_mhold0: assert property (p_mhold0)
    else $error("master moved while clock high");

property p_mhold1;
    clk_en_i && eff_clk[1] |=> $stable(master_ff[1]);
endproperty
a_mhold1: assert property (p_mhold1)
    else $error("master moved while clock high");

property p_mhold2;
    clk_en_i && eff_clk[2] |=> $stable(master_ff[2]);
endproperty
a_mhold2: assert property (p_mhold2)
    else $error("master moved while clock high");

////////////////////////////////////////////////////////////////////////

property p_freeze;
    !clk_en_i |=> $stable(stage_out_o) && $stable(master_ff);
endproperty
a_freeze: assert property (p_freeze)
    else $error("state moved while frozen");

c_set: cover property (shared_set_i ##1 stage_out_o == 3'h7);
c_clr: cover property (shared_clear_i ##1 stage_out_o == 3'h0);
c_edge: cover property ($rose(shared_clock_i) ##1 $changed(stage_out_o));
c_frz: cover property (!clk_en_i && shared_set_i ##1 stage_out_o == 3'h0);
c_own: cover property ($rose(stage_clock_i[1]) && !shared_clock_i
    ##1 stage_out_o[1]);

endmodule
`default_nettype wire

// ### triple_dff_cfg.svh
`ifndef TRIPLE_DFF_CFG_SVH
`define TRIPLE_DFF_CFG_SVH
`define STAGE_COUNT 3
`define STAGE_RESET_VAL 1'h0
`endif

// ### triple_dff_pkg.sv
`default_nettype none
package triple_dff_pkg;
    typedef logic [2:0] stage_vec_t;
endpackage
`default_nettype wire

// ### drive_model.sv
`default_nettype none
module drive_model
(
    input wire logic clock_i,
    output var logic shared_clock_o = 1'h0,
    output var triple_dff_pkg::stage_vec_t stage_clock_o = 3'h0,
    output var triple_dff_pkg::stage_vec_t stage_data_o = 3'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic tick(logic c, triple_dff_pkg::stage_vec_t k, d);
        @(posedge clock_i);
        #1 {shared_clock_o, stage_clock_o, stage_data_o} = {c, k, d};
    endtask
endmodule
`default_nettype wire

// ### triple_dff_tb_top.sv
`default_nettype none
module triple_dff_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'h0, rst_n_i = 1'h0, ss = 1'h0, sr = 1'h0, sc;
    logic en = 1'h1;
    triple_dff_pkg::stage_vec_t st = 3'h0, cr = 3'h0, cl, d, q, qn;
    int fail_count = 0, checked = 0;
    always #2 clock_i = ~clock_i;
    drive_model u_drv(.clock_i, .shared_clock_o(sc), .stage_clock_o(cl),
        .stage_data_o(d));
    triple_dff DUT(.clock_i, .rst_n_i, .clk_en_i(en), .shared_clock_i(sc),
        .shared_set_i(ss), .shared_clear_i(sr), .stage_clock_i(cl),
        .stage_set_i(st), .stage_clear_i(cr), .stage_data_in_i(d),
        .stage_out_o(q), .stage_out_inverted_o(qn));
    task automatic chk(triple_dff_pkg::stage_vec_t e);
        repeat (3) @(posedge clock_i);
        #1 checked += 2; // Let the edge's updates land first.
        if ({q, qn} !== {e, ~e}) begin
            fail_count++;
            $display("MISMATCH out exp %h got %h", e, q);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic t_clocked();
        u_drv.tick(1'h0, 3'h0, 3'h5);
        u_drv.tick(1'h0, 3'h7, 3'h2);
        chk(3'h5);
        u_drv.tick(1'h0, 3'h0, 3'h2);
        u_drv.tick(1'h1, 3'h0, 3'h0);
        chk(3'h2);
    endtask
    task automatic t_forced();
        @(posedge clock_i) #1 {st, cr} = {3'h1, 3'h2};
        chk(3'h1);
        @(posedge clock_i) #1 {ss, st, cr} = {1'h1, 6'h00};
        chk(3'h7);
        @(posedge clock_i) #1 {ss, sr} = {1'h0, 1'h1};
        chk(3'h0);
    endtask
    task automatic t_freeze();
        @(posedge clock_i) #1 {sr, ss, en} = {1'h0, 1'h1, 1'h0};
        chk(3'h0);
        @(posedge clock_i) #1 {ss, en} = {1'h0, 1'h1};
        u_drv.tick(1'h0, 3'h0, 3'h7);
        u_drv.tick(1'h0, 3'h2, 3'h0);
        chk(3'h2);
    endtask
    initial begin
        repeat (20) @(posedge clock_i);
        #1 rst_n_i = 1'h1;
        chk(3'h0);
        t_clocked();
        t_forced();
        t_freeze();
        stop_test();
    end
    initial begin
        #1000 fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
